// file: src/iofb_flag_bank.sv
// I/O, supply, serial, wake and mode-history sticky flag bank
`timescale 1ns/10ps
module iofb_flag_bank
  import iofb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic serial_flag_read,
  input wire logic hs3_gnd_fault,
  input wire logic hs2_gnd_fault,
  input wire logic second_supply_low,
  input wire logic first_supply_high,
  input wire logic hs0_thermal_fault,
  input wire logic serial_select_n,
  input wire logic debug_entry_pin,
  input wire logic parity_err_pulse,
  input wire logic prog_mode,
  input wire logic wdog_restart,
  input wire logic wake_13_pulse,
  input wire logic wake_02_pulse,
  input wire logic serial_wake_pulse,
  input wire logic low_power_regulator_on,
  input wire logic forced_wakeup_pulse,
  input wire logic int_timeout_pulse,
  input wire logic low_power_regulator_off,
  input wire logic reset_cmd_pulse,
  input wire logic debug_mode,
  output logic [15:0] flags
);

  iofb_state_t q;
  iofb_state_t d;
  logic [15:0] set_ev;
  logic [15:0] live;
  logic flag_read;

  // Address decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================================
  // Event collection
  // ==========================================================================
  // Live fault levels, after two-stage synchronisers
  always_comb
  begin
    live = '0;
    live[B_HS3_GND] = q.fault_s2[0];
    live[B_HS2_GND] = q.fault_s2[1];
    live[B_SUP2_LOW] = q.fault_s2[2];
    live[B_SUP1_HIGH] = q.fault_s2[3];
    live[B_HS0_THERM] = q.fault_s2[4];
  end

  // A serial group read and a status register read clear alike
  assign flag_read = serial_flag_read | (rd_stb & hit(addr, OFS_STATUS));

  // Set sources for each flag
  always_comb
  begin
    set_ev = live;
    set_ev[B_PARITY] = parity_err_pulse;
    set_ev[B_SEL_LONG] = (q.sel_cnt == 17'(SEL_LONG_CYC)) & ~q.sel_long_done;
    set_ev[B_WDOG_HALF] = prog_mode & ~q.wdog_half_done
      & (q.wdog_cnt > {1'b0, q.wdog_period[15:1]});
    set_ev[B_WAKE_13] = wake_13_pulse;
    set_ev[B_WAKE_02] = wake_02_pulse;
    set_ev[B_SER_WAKE] = serial_wake_pulse & low_power_regulator_on;
    set_ev[B_FORCED_WAKE] = forced_wakeup_pulse;
    set_ev[B_INT_TMO] = int_timeout_pulse;
    set_ev[B_LP_OFF] = low_power_regulator_off;
    set_ev[B_RST_REQ] = reset_cmd_pulse;
    // Falling pin edge, seen between the second and third stages
    set_ev[B_DEBUG_LEAVE] = debug_mode & q.debug_sync[2] & ~q.debug_sync[1];
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    d = q;
    d.fault_s1 = {3'b000, hs0_thermal_fault, first_supply_high, second_supply_low,
      hs2_gnd_fault, hs3_gnd_fault};
    d.fault_s2 = q.fault_s1;
    d.sel_sync = {q.sel_sync[0], serial_select_n};
    // Third stage only serves the edge detector, never the first stage
    d.debug_sync = {q.debug_sync[1:0], debug_entry_pin};
    // Select-low timer, saturating at the threshold
    if (q.sel_sync[1])
    begin
      d.sel_cnt = '0;
      d.sel_long_done = 1'b0;
    end
    else if (q.sel_cnt != 17'(SEL_LONG_CYC))
    begin
      d.sel_cnt = q.sel_cnt + 17'd1;
    end
    else
    begin
      d.sel_long_done = 1'b1;
    end
    // Watchdog elapsed counter in programming mode
    if (!prog_mode || wdog_restart)
    begin
      d.wdog_cnt = '0;
      d.wdog_half_done = 1'b0;
    end
    else if (q.wdog_cnt != 16'hFFFF)
    begin
      d.wdog_cnt = q.wdog_cnt + 16'h0001;
    end
    if (set_ev[B_WDOG_HALF])
    begin
      d.wdog_half_done = 1'b1;
    end
    // Read clears; a held fault or new event keeps the flag set
    if (flag_read)
    begin
      d.flags = set_ev | (q.flags & COND_MASK & live);
    end
    else
    begin
      d.flags = q.flags | set_ev;
    end
    // Register writes
    if (wr_stb && hit(addr, OFS_MASK))
    begin
      d.mask = wdata[15:0];
    end
    if (wr_stb && hit(addr, OFS_WDOG))
    begin
      d.wdog_period = wdata[15:0];
    end
    // Read data, held one cycle only
    d.rdata = '0;
    if (rd_stb)
    begin
      case (addr)
        OFS_STATUS: d.rdata = {16'h0000, q.flags};
        OFS_MASK: d.rdata = {16'h0000, q.mask};
        OFS_LIVE: d.rdata = {16'h0000, live};
        OFS_WDOG: d.rdata = {16'h0000, q.wdog_period};
        default: d.rdata = '0;
      endcase
    end
    if (reset)
    begin
      d = '0;
      d.sel_sync = 2'b11;
      d.mask = MASK_RST;
      d.wdog_period = WDOG_RST;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  // Outputs come from the state register only; irq ORs the masked flags
  assign rdata = q.rdata;
  assign flags = q.flags;
  assign irq = |(q.flags & q.mask);

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_held_fault;
    live[B_HS3_GND] && flag_read;
  endsequence

  chk_cond_flag_hold: assert property (@(posedge clk) disable iff (reset)
    s_held_fault |=> flags[B_HS3_GND]) else $error("held fault flag cleared");
  chk_hs2_recover: assert property (@(posedge clk) disable iff (reset)
    flags[B_HS2_GND] && !live[B_HS2_GND] && !flag_read |=> flags[B_HS2_GND])
    else $error("hs2 flag lost without read");
  chk_parity_set: assert property (@(posedge clk) disable iff (reset)
    parity_err_pulse |=> flags[B_PARITY]) else $error("parity flag missed");
  chk_parity_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !parity_err_pulse |=> !flags[B_PARITY]) else $error("parity flag not cleared");
  chk_sel_long_set: assert property (@(posedge clk) disable iff (reset)
    q.sel_cnt == 17'(SEL_LONG_CYC - 1) && !q.sel_sync[1] |=> ##1 flags[B_SEL_LONG])
    else $error("select long flag missed");
  chk_sup2_set: assert property (@(posedge clk) disable iff (reset)
    live[B_SUP2_LOW] |=> flags[B_SUP2_LOW]) else $error("supply low flag missed");
  chk_sup1_set: assert property (@(posedge clk) disable iff (reset)
    live[B_SUP1_HIGH] |=> flags[B_SUP1_HIGH]) else $error("supply high flag missed");
  chk_therm_set: assert property (@(posedge clk) disable iff (reset)
    live[B_HS0_THERM] |=> flags[B_HS0_THERM]) else $error("thermal flag missed");
  chk_wdog_mode: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_WDOG_HALF]) |-> $past(prog_mode)) else $error("watchdog flag outside mode");
  chk_wake13_set: assert property (@(posedge clk) disable iff (reset)
    wake_13_pulse |=> flags[B_WAKE_13]) else $error("wake 1/3 flag missed");
  chk_wake02_set: assert property (@(posedge clk) disable iff (reset)
    wake_02_pulse |=> flags[B_WAKE_02]) else $error("wake 0/2 flag missed");
  chk_ser_wake: assert property (@(posedge clk) disable iff (reset)
    serial_wake_pulse && low_power_regulator_on |=> flags[B_SER_WAKE]) else $error("serial wake missed");
  chk_forced_set: assert property (@(posedge clk) disable iff (reset)
    forced_wakeup_pulse |=> flags[B_FORCED_WAKE]) else $error("forced wake missed");
  chk_int_tmo: assert property (@(posedge clk) disable iff (reset)
    int_timeout_pulse |=> flags[B_INT_TMO]) else $error("timeout flag missed");
  chk_lp_off: assert property (@(posedge clk) disable iff (reset)
    low_power_regulator_off |=> flags[B_LP_OFF]) else $error("regulator off flag missed");
  chk_rst_req: assert property (@(posedge clk) disable iff (reset)
    reset_cmd_pulse |=> flags[B_RST_REQ]) else $error("reset request flag missed");
  chk_debug_leave: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_DEBUG_LEAVE]) |-> $past(debug_mode)) else $error("debug leave without mode");
  chk_read_value: assert property (@(posedge clk) disable iff (reset)
    rd_stb && addr == OFS_STATUS |=> rdata[15:0] == $past(flags)) else $error("read data wrong");

  // ==========================================================================
  // Checks on reset and the register port
  // ==========================================================================
  // Reset leaves every flag, the read data and the interrupt low
  chk_reset_state: assert property (@(posedge clk)
    reset |=> flags == 16'h0000 && rdata == 32'h00000000 && !irq)
    else $error("state not cleared by reset");
  // Read data stands only in the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !rd_stb |=> rdata == 32'h00000000) else $error("read data without read");
  chk_rdata_upper: assert property (@(posedge clk) disable iff (reset)
    rd_stb |=> rdata[31:16] == 16'h0000) else $error("upper read bits set");
  chk_live_read: assert property (@(posedge clk) disable iff (reset)
    rd_stb && addr == OFS_LIVE |=> rdata[15:0] == $past(live)) else $error("live read wrong");
  // Writes land in the mask and the watchdog period
  chk_mask_write: assert property (@(posedge clk) disable iff (reset)
    wr_stb && addr == OFS_MASK |=> q.mask == $past(wdata[15:0])) else $error("mask write lost");
  chk_wdog_write: assert property (@(posedge clk) disable iff (reset)
    wr_stb && addr == OFS_WDOG |=> q.wdog_period == $past(wdata[15:0])) else $error("period write lost");

  // ==========================================================================
  // Checks on the flags that wait for recovery
  // ==========================================================================
  // Read steps with the fault already gone
  sequence s_read_hs3_gone;
    flag_read && !live[B_HS3_GND];
  endsequence
  sequence s_read_hs2_gone;
    flag_read && !live[B_HS2_GND];
  endsequence
  sequence s_read_sup2_gone;
    flag_read && !live[B_SUP2_LOW];
  endsequence
  sequence s_read_sup1_gone;
    flag_read && !live[B_SUP1_HIGH];
  endsequence
  sequence s_read_therm_gone;
    flag_read && !live[B_HS0_THERM];
  endsequence
  // Recovery plus read clears each condition flag
  chk_hs3_clear: assert property (@(posedge clk) disable iff (reset)
    s_read_hs3_gone |=> !flags[B_HS3_GND]) else $error("hs3 flag not cleared");
  chk_hs2_clear: assert property (@(posedge clk) disable iff (reset)
    s_read_hs2_gone |=> !flags[B_HS2_GND]) else $error("hs2 flag not cleared");
  chk_sup2_clear: assert property (@(posedge clk) disable iff (reset)
    s_read_sup2_gone |=> !flags[B_SUP2_LOW]) else $error("supply low not cleared");
  chk_sup1_clear: assert property (@(posedge clk) disable iff (reset)
    s_read_sup1_gone |=> !flags[B_SUP1_HIGH]) else $error("supply high not cleared");
  chk_therm_clear: assert property (@(posedge clk) disable iff (reset)
    s_read_therm_gone |=> !flags[B_HS0_THERM]) else $error("thermal flag not cleared");
  // A live fault keeps its flag through a read
  chk_hs2_hold: assert property (@(posedge clk) disable iff (reset)
    live[B_HS2_GND] && flag_read |=> flags[B_HS2_GND]) else $error("hs2 flag dropped");
  chk_sup2_hold: assert property (@(posedge clk) disable iff (reset)
    live[B_SUP2_LOW] && flag_read |=> flags[B_SUP2_LOW]) else $error("supply low dropped");
  chk_sup1_hold: assert property (@(posedge clk) disable iff (reset)
    live[B_SUP1_HIGH] && flag_read |=> flags[B_SUP1_HIGH]) else $error("supply high dropped");
  chk_therm_hold: assert property (@(posedge clk) disable iff (reset)
    live[B_HS0_THERM] && flag_read |=> flags[B_HS0_THERM]) else $error("thermal flag dropped");
  // Without a read a recovered fault keeps its flag
  chk_hs3_recover: assert property (@(posedge clk) disable iff (reset)
    flags[B_HS3_GND] && !live[B_HS3_GND] && !flag_read |=> flags[B_HS3_GND])
    else $error("hs3 flag lost without read");
  chk_sup2_recover: assert property (@(posedge clk) disable iff (reset)
    flags[B_SUP2_LOW] && !live[B_SUP2_LOW] && !flag_read |=> flags[B_SUP2_LOW])
    else $error("supply low lost without read");
  chk_therm_recover: assert property (@(posedge clk) disable iff (reset)
    flags[B_HS0_THERM] && !live[B_HS0_THERM] && !flag_read |=> flags[B_HS0_THERM])
    else $error("thermal flag lost without read");

  // ==========================================================================
  // Checks on the flags cleared by a read alone
  // ==========================================================================
  // A read with no new event clears the flag
  chk_sel_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !set_ev[B_SEL_LONG] |=> !flags[B_SEL_LONG])
    else $error("select flag not cleared");
  chk_wdog_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !set_ev[B_WDOG_HALF] |=> !flags[B_WDOG_HALF])
    else $error("watchdog flag not cleared");
  chk_wake13_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !wake_13_pulse |=> !flags[B_WAKE_13]) else $error("wake 1/3 not cleared");
  chk_wake02_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !wake_02_pulse |=> !flags[B_WAKE_02]) else $error("wake 0/2 not cleared");
  chk_ser_wake_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !(serial_wake_pulse && low_power_regulator_on) |=> !flags[B_SER_WAKE])
    else $error("serial wake not cleared");
  chk_forced_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !forced_wakeup_pulse |=> !flags[B_FORCED_WAKE]) else $error("forced wake not cleared");
  chk_tmo_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !int_timeout_pulse |=> !flags[B_INT_TMO]) else $error("timeout not cleared");
  chk_lp_off_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !low_power_regulator_off |=> !flags[B_LP_OFF]) else $error("regulator off not cleared");
  chk_rst_req_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !reset_cmd_pulse |=> !flags[B_RST_REQ]) else $error("reset request not cleared");
  chk_debug_clear: assert property (@(posedge clk) disable iff (reset)
    flag_read && !set_ev[B_DEBUG_LEAVE] |=> !flags[B_DEBUG_LEAVE])
    else $error("debug leave not cleared");
  // A flag rises only on its own cause
  chk_wake13_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_WAKE_13]) |-> $past(wake_13_pulse)) else $error("wake 1/3 without event");
  chk_wake02_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_WAKE_02]) |-> $past(wake_02_pulse)) else $error("wake 0/2 without event");
  chk_ser_wake_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_SER_WAKE]) |-> $past(low_power_regulator_on)) else $error("serial wake outside mode");
  chk_forced_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_FORCED_WAKE]) |-> $past(forced_wakeup_pulse)) else $error("forced wake without event");
  chk_tmo_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_INT_TMO]) |-> $past(int_timeout_pulse)) else $error("timeout without event");
  chk_lp_off_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_LP_OFF]) |-> $past(low_power_regulator_off)) else $error("regulator off without mode");
  chk_rst_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_RST_REQ]) |-> $past(reset_cmd_pulse)) else $error("reset request without command");
  chk_parity_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_PARITY]) |-> $past(parity_err_pulse)) else $error("parity flag without error");

  // ==========================================================================
  // Checks on the timers and the pin edge
  // ==========================================================================
  // Select high restarts the low-time count
  chk_sel_restart: assert property (@(posedge clk) disable iff (reset)
    q.sel_sync[1] |=> q.sel_cnt == 17'h00000) else $error("select count not restarted");
  chk_sel_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_SEL_LONG]) |-> $past(q.sel_cnt) == 17'(SEL_LONG_CYC))
    else $error("select flag before limit");
  // Watchdog count restarts and the half mark
  chk_wdog_restart: assert property (@(posedge clk) disable iff (reset)
    !prog_mode || wdog_restart |=> q.wdog_cnt == 16'h0000) else $error("watchdog count not restarted");
  chk_wdog_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_WDOG_HALF]) |-> $past(q.wdog_cnt) > {1'b0, $past(q.wdog_period[15:1])})
    else $error("watchdog flag before half");
  // Debug leave needs a falling pin edge
  chk_debug_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(flags[B_DEBUG_LEAVE]) |-> $past(q.debug_sync[2]) && !$past(q.debug_sync[1]))
    else $error("debug leave without pin fall");

endmodule : iofb_flag_bank

// file: src/iofb_pkg.sv
// Package of constants and types for the I/O status flag bank
package iofb_pkg;

  // ==========================================================================
  // Flag bit positions
  // ==========================================================================
  localparam int FLAG_W = 16;
  localparam int B_HS3_GND = 0;
  localparam int B_HS2_GND = 1;
  localparam int B_PARITY = 2;
  localparam int B_SEL_LONG = 3;
  localparam int B_SUP2_LOW = 4;
  localparam int B_SUP1_HIGH = 5;
  localparam int B_HS0_THERM = 6;
  localparam int B_WDOG_HALF = 7;
  localparam int B_WAKE_13 = 8;
  localparam int B_WAKE_02 = 9;
  localparam int B_SER_WAKE = 10;
  localparam int B_FORCED_WAKE = 11;
  localparam int B_INT_TMO = 12;
  localparam int B_LP_OFF = 13;
  localparam int B_RST_REQ = 14;
  localparam int B_DEBUG_LEAVE = 15;

  // Flags that need the fault gone before a read may clear them
  localparam logic [15:0] COND_MASK = 16'h0073;

  // ==========================================================================
  // Register map (word offsets as byte addresses)
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_LIVE = 8'h08;
  localparam logic [7:0] OFS_WDOG = 8'h0C;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] WDOG_RST = 16'h0100;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ = 40000000;
  localparam int SEL_LONG_US = 2000;
  localparam int SEL_LONG_CYC = (CLK_HZ / 1000000) * SEL_LONG_US;
  localparam int SEL_CNT_W = 17;

  // State of the bank
  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] mask;
    logic [15:0] wdog_period;
    logic [31:0] rdata;
    logic [16:0] sel_cnt;
    logic sel_long_done;
    logic [15:0] wdog_cnt;
    logic wdog_half_done;
    logic [1:0] sel_sync;
    logic [2:0] debug_sync;
    logic [7:0] fault_s1;
    logic [7:0] fault_s2;
  } iofb_state_t;

endpackage : iofb_pkg

// file: test/iofb_host_model.sv
// Host model that issues the serial flag-group read
`timescale 1ns/10ps
module iofb_host_model
  import iofb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req,
  output logic serial_flag_read
);
  // ==========================================================================
  // Serial read strobe
  // ==========================================================================
  // Read strobe copies req one cycle later, for as many cycles as req is high, and is low in the cycle after any cycle with reset high
  always_ff @(posedge clk)
  begin
    serial_flag_read <= req && !reset;
  end
endmodule : iofb_host_model

// file: test/tb.sv
// Testbench for the I/O status flag bank
`timescale 1ns/10ps
module tb
  import iofb_pkg::*;
;
  logic clk = 0, reset = 1, wr_stb = 0, rd_stb = 0, req = 0, sel_n = 1, debug_pin = 0;
  logic prog = 0, lp_on = 0, lp_off = 0, debug_md = 0, sfr;
  logic [7:0] addr = 8'h00, ev = 8'h00;
  logic [4:0] fv = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [15:0] flags;
  logic irq;
  int num_errors = 0, total_checks = 0;
  int ebit[7] = '{B_PARITY, B_WAKE_13, B_WAKE_02, B_SER_WAKE, B_FORCED_WAKE, B_INT_TMO, B_RST_REQ};
  int fbit[5] = '{B_HS3_GND, B_HS2_GND, B_SUP2_LOW, B_SUP1_HIGH, B_HS0_THERM};
  // ==========================================================================
  // Clock, design and host
  // ==========================================================================
  // Free-running 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  iofb_flag_bank uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .serial_flag_read(sfr), .hs3_gnd_fault(fv[0]),
    .hs2_gnd_fault(fv[1]), .second_supply_low(fv[2]), .first_supply_high(fv[3]),
    .hs0_thermal_fault(fv[4]), .serial_select_n(sel_n), .debug_entry_pin(debug_pin),
    .parity_err_pulse(ev[0]), .prog_mode(prog), .wdog_restart(ev[7]), .wake_13_pulse(ev[1]),
    .wake_02_pulse(ev[2]), .serial_wake_pulse(ev[3]), .low_power_regulator_on(lp_on),
    .forced_wakeup_pulse(ev[4]), .int_timeout_pulse(ev[5]), .low_power_regulator_off(lp_off),
    .reset_cmd_pulse(ev[6]), .debug_mode(debug_md), .flags(flags));
  iofb_host_model host (.clk(clk), .reset(reset), .req(req), .serial_flag_read(sfr));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_stb <= 1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 0;
    #1 d = rdata;
  endtask : rd
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev[i] <= 0;
    #1;
  endtask : pulse
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // Watchdog against a hang
  initial
  begin
    #(25ns * 100000);
    num_errors++;
    summarize();
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 0;
    #1 chk("flags_rst", {16'h0, flags}, 32'h0);
    rd(OFS_MASK, v); chk("mask_rst", v, {16'h0, MASK_RST});
    rd(OFS_WDOG, v); chk("wdog_rst", v, {16'h0, WDOG_RST});
    rd(8'hF0, v); chk("unmapped", v, 32'h0);
    // Serial wake without regulator-on low power is ignored
    pulse(3); chk("swake_off", flags[B_SER_WAKE], 1'b0);
    @(posedge clk);
    lp_on <= 1;
    for (int i = 0; i < 7; i++)
    begin
      pulse(i); chk("ev_set", flags[ebit[i]], 1'b1);
      rd(OFS_STATUS, v); chk("ev_read", v, 32'h1 << ebit[i]);
      chk("ev_clr", {16'h0, flags}, 32'h0);
    end
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      fv[i] <= 1;
      wait_cyc(5); chk("flt_set", flags[fbit[i]], 1'b1);
      rd(OFS_LIVE, v); chk("flt_level", v, 32'h1 << fbit[i]);
      rd(OFS_STATUS, v); chk("flt_read", v, 32'h1 << fbit[i]);
      chk("flt_live", flags[fbit[i]], 1'b1);
      @(posedge clk);
      fv[i] <= 0;
      wait_cyc(5); chk("flt_stick", flags[fbit[i]], 1'b1);
      rd(OFS_STATUS, v); chk("flt_clr", flags[fbit[i]], 1'b0);
    end
    // Event in the clearing cycle survives, interrupt follows mask
    wr(OFS_MASK, 32'h1 << B_PARITY);
    @(posedge clk);
    rd_stb <= 1; addr <= OFS_STATUS; ev[0] <= 1;
    @(posedge clk);
    rd_stb <= 0; ev[0] <= 0;
    #1 chk("set_wins", flags[B_PARITY], 1'b1);
    wait_cyc(1); chk("irq_on", irq, 1'b1);
    @(posedge clk);
    req <= 1;
    @(posedge clk);
    req <= 0;
    wait_cyc(3);
    chk("serial_clr", {irq, flags[B_PARITY]}, 32'h0);
    // Mode-history flags
    @(posedge clk);
    lp_off <= 1;
    wait_cyc(2);
    @(posedge clk);
    lp_off <= 0;
    #1 chk("lp_off", flags[B_LP_OFF], 1'b1);
    @(posedge clk);
    debug_pin <= 1;
    debug_md <= 1;
    wait_cyc(5); chk("dbg_rise", flags[B_DEBUG_LEAVE], 1'b0);
    @(posedge clk);
    debug_pin <= 0;
    wait_cyc(5); chk("dbg_leave", flags[B_DEBUG_LEAVE], 1'b1);
    wr(OFS_WDOG, 32'h10);
    pulse(7);
    @(posedge clk);
    prog <= 1;
    wait_cyc(4); chk("wd_early", flags[B_WDOG_HALF], 1'b0);
    wait_cyc(10); chk("wd_half", flags[B_WDOG_HALF], 1'b1);
    @(posedge clk);
    prog <= 0;
    rd(OFS_STATUS, v); chk("hist_read", v,
      (32'h1 << B_LP_OFF) | (32'h1 << B_DEBUG_LEAVE) | (32'h1 << B_WDOG_HALF));
    chk("hist_clr", {16'h0, flags}, 32'h0);
    // Select held low beyond the long-select limit
    @(posedge clk);
    sel_n <= 0;
    wait_cyc(SEL_LONG_CYC - 100); chk("sel_early", flags[B_SEL_LONG], 1'b0);
    wait_cyc(110); chk("sel_long", flags[B_SEL_LONG], 1'b1);
    @(posedge clk);
    sel_n <= 1;
    rd(OFS_STATUS, v); chk("sel_read", v, 32'h1 << B_SEL_LONG);
    chk("sel_clr", flags[B_SEL_LONG], 1'b0);
    summarize();
  end
endmodule : tb
